// *** rtl/pmurc_pkg.sv ***
// Constants, register map and lookup tables of the regulator control bank
package pmurc_pkg;
	// Register port widths
	localparam int REG_ADDR_W = 8;
	localparam int REG_DATA_W = 8;
	localparam int REG_COUNT  = 12;
	localparam int REG_NUM    = 9;
	// Register offsets
	localparam logic [7:0] ADDR_GENERAL_CONTROL  = 8'h00;
	localparam logic [7:0] ADDR_LDO_ONE_OUTPUT   = 8'h01;
	localparam logic [7:0] ADDR_STEPDOWN_ONE_A   = 8'h08;
	localparam logic [7:0] ADDR_STEPDOWN_ONE_B   = 8'h09;
	localparam logic [7:0] ADDR_STEPDOWN_TWO_A   = 8'h0A;
	localparam logic [7:0] ADDR_STEPDOWN_TWO_B   = 8'h0B;
	// Reset value of every register (defaults differ by variant)
	localparam logic [7:0] REG_RESET_VALUE       = 8'h00;
	// Writable bit masks; unused positions stay zero
	localparam logic [7:0] GENERAL_WRITE_MASK    = 8'hDF;
	localparam logic [7:0] CURRENT_WRITE_MASK    = 8'hDF;
	localparam logic [7:0] OUTPUT_WRITE_MASK     = 8'hFF;
	// General control field positions
	localparam int BIT_STEP_RANGE    = 7;
	localparam int BIT_STEP_FINE     = 6;
	localparam int BIT_TWO_ENABLE    = 4;
	localparam int BIT_TWO_SOURCE    = 3;
	localparam int BIT_ONE_SOURCE    = 2;
	localparam int BIT_LDO_SLEEP     = 1;
	localparam int BIT_ONE_ENABLE    = 0;
	// Output register field positions
	localparam int DELAY_MSB   = 7;
	localparam int DELAY_LSB   = 5;
	localparam int CLIMIT_MSB  = 7;
	localparam int CLIMIT_LSB  = 6;
	localparam int VCODE_MSB   = 4;
	// Sequencing time steps in microseconds and clock rate
	localparam int CLK_MHZ     = 10;
	localparam int STEP_32_US  = 32;
	localparam int STEP_64_US  = 64;
	localparam int STEP_128_US = 128;
	localparam int STEP_256_US = 256;
	localparam logic [11:0] STEP_32_CYC  = 12'(STEP_32_US * CLK_MHZ);
	localparam logic [11:0] STEP_64_CYC  = 12'(STEP_64_US * CLK_MHZ);
	localparam logic [11:0] STEP_128_CYC = 12'(STEP_128_US * CLK_MHZ);
	localparam logic [11:0] STEP_256_CYC = 12'(STEP_256_US * CLK_MHZ);
	// Peak current limit in mA by field code
	localparam logic [10:0] CLIMIT_MA [4] = '{11'h1CC, 11'h30C, 11'h41A, 11'h55A};
	// Voltage tables, output in units of 50 mV
	typedef enum logic [1:0] {PMURC_TAB_LDO, PMURC_TAB_LOWIN, PMURC_TAB_STEPDOWN} pmurc_tab_e;
	localparam logic [6:0] LDO_TAB [32] = '{
		7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h1F,
		7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h28,
		7'h2A, 7'h2C, 7'h2E, 7'h30, 7'h32, 7'h34, 7'h35, 7'h36,
		7'h37, 7'h38, 7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3E, 7'h42};
	localparam logic [6:0] LOWIN_TAB [32] = '{
		7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
		7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1E, 7'h20, 7'h22,
		7'h24, 7'h26, 7'h28, 7'h2A, 7'h2C, 7'h2E, 7'h30, 7'h32,
		7'h34, 7'h36, 7'h38, 7'h39, 7'h3A, 7'h3C, 7'h3E, 7'h3E};
	localparam logic [6:0] STEPDOWN_TAB [32] = '{
		7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
		7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1E, 7'h20, 7'h22,
		7'h23, 7'h24, 7'h25, 7'h26, 7'h28, 7'h2A, 7'h2C, 7'h2E,
		7'h30, 7'h32, 7'h34, 7'h36, 7'h38, 7'h39, 7'h3A, 7'h3C};
endpackage

// *** rtl/pmurc_vmap.sv ***
// Registered translation of a 5-bit voltage code into 50 mV units
`timescale 1ns/1ps
module pmurc_vmap
	import pmurc_pkg::*;
#(
	parameter pmurc_tab_e TABLE = PMURC_TAB_LDO
)
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Code in, level out
	input  wire logic [4:0] volt_code,
	output logic      [6:0] volt_level
);
	// Lookup of the table this instance serves
	function automatic logic [6:0] map_code(input logic [4:0] code);
		logic [6:0] lvl;
		lvl = LDO_TAB[code];
		if (TABLE == PMURC_TAB_LOWIN)
			lvl = LOWIN_TAB[code];
		else if (TABLE == PMURC_TAB_STEPDOWN)
			lvl = STEPDOWN_TAB[code];
		return lvl;
	endfunction

	// Level register, one cycle behind the code
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			volt_level <= 7'h00;
		else
			volt_level <= map_code(volt_code);
	end
endmodule

// *** rtl/pmurc_regs.sv ***
// Regulator control register bank of the power management unit
`timescale 1ns/1ps
module pmurc_regs
	import pmurc_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	// Register port from the serial interface
	input  wire logic                  reg_wr_en,
	input  wire logic [REG_ADDR_W-1:0] reg_addr,
	input  wire logic [REG_DATA_W-1:0] reg_wr_data,
	output logic      [REG_DATA_W-1:0] reg_rd_data,
	// Power state from the sequencer, high in idle
	input  wire logic                  pmu_idle,
	// Voltage scaling pin, asynchronous
	input  wire logic                  external_voltage_scale_pin,
	// Converter switch and sequencing controls
	output logic                       stepdown_one_on,
	output logic                       stepdown_two_on,
	output logic                       stepdown_one_include,
	output logic                       stepdown_two_include,
	output logic                       ldo_sleep,
	output logic      [11:0]           sequence_step_cycles,
	// Per-regulator settings
	output logic      [REG_NUM-1:0][2:0] startup_delay_field,
	output logic      [REG_NUM-1:0][6:0] regulator_voltage,
	output logic      [1:0][10:0]        peak_current_limit_ma
);
	// Register storage
	logic [7:0]  regs_reg [REG_COUNT];
	// Pin synchroniser stages and accepted level
	logic        pin_s1_reg;
	logic        pin_s2_reg;
	logic        pin_s3_reg;
	logic        pin_level_reg;
	// Converter switch state
	logic        one_on_reg;
	logic        two_on_reg;
	logic        one_on_next;
	logic        two_on_next;
	// Sleep, step and current limit registers
	logic        sleep_reg;
	logic [11:0] step_reg;
	logic [11:0] step_next;
	logic [10:0] climit_one_reg;
	logic [10:0] climit_two_reg;
	logic [7:0]  rd_reg;
	// Decode and selection wires
	logic        addr_mapped;
	logic        wr_hit;
	logic        gen_wr;
	logic [7:0]  gen_now;
	logic [7:0]  gen_next;
	logic [7:0]  wr_value;
	logic [7:0]  rd_next;
	logic [4:0]  one_code;
	logic [4:0]  two_code;
	logic [REG_NUM-1:0][4:0] reg_code;

	// Write mask by offset
	function automatic logic [7:0] write_mask(input logic [7:0] addr);
		logic [7:0] m;
		m = OUTPUT_WRITE_MASK;
		if (addr == ADDR_GENERAL_CONTROL)
			m = GENERAL_WRITE_MASK;
		else if (addr == ADDR_STEPDOWN_ONE_B || addr == ADDR_STEPDOWN_TWO_B)
			m = CURRENT_WRITE_MASK;
		return m;
	endfunction

	// Time step selection from range and fine bits
	function automatic logic [11:0] step_of(input logic range, input logic fine);
		logic [11:0] c;
		if (!range)
			c = fine ? STEP_64_CYC : STEP_32_CYC;
		else
			c = fine ? STEP_256_CYC : STEP_128_CYC;
		return c;
	endfunction

	// Address decode
	assign addr_mapped = (reg_addr < REG_ADDR_W'(REG_COUNT));
	assign wr_hit      = reg_wr_en && addr_mapped;
	assign gen_wr      = reg_wr_en && (reg_addr == ADDR_GENERAL_CONTROL);
	// Masked write value, unused bits dropped
	assign wr_value    = reg_wr_data & write_mask(reg_addr);
	// Read value, unmapped offsets read zero
	assign rd_next     = addr_mapped ? regs_reg[reg_addr[3:0]] : 8'h00;
	// General register as it stands now, and as it stands after this edge
	assign gen_now     = regs_reg[0];
	assign gen_next    = gen_wr ? wr_value : gen_now;

	// Switch state: off in standby, follows enable at once in idle
	assign one_on_next = pmu_idle && gen_next[BIT_ONE_ENABLE];
	assign two_on_next = pmu_idle && gen_next[BIT_TWO_ENABLE];

	// Time step count from the general register
	assign step_next = step_of(gen_now[BIT_STEP_RANGE], gen_now[BIT_STEP_FINE]);

	// Converter one: own code when selected, else the pin picks a or b
	assign one_code = gen_now[BIT_ONE_SOURCE] ? regs_reg[8][VCODE_MSB:0]
		: (pin_level_reg ? regs_reg[9][VCODE_MSB:0] : regs_reg[8][VCODE_MSB:0]);
	// Converter two: first code when selected, else second
	assign two_code = gen_now[BIT_TWO_SOURCE] ? regs_reg[10][VCODE_MSB:0]
		: regs_reg[11][VCODE_MSB:0];

	// Codes fed to the voltage tables: five LDOs, two low-input, two converters
	assign reg_code[0] = regs_reg[1][VCODE_MSB:0];
	assign reg_code[1] = regs_reg[2][VCODE_MSB:0];
	assign reg_code[2] = regs_reg[3][VCODE_MSB:0];
	assign reg_code[3] = regs_reg[4][VCODE_MSB:0];
	assign reg_code[4] = regs_reg[5][VCODE_MSB:0];
	assign reg_code[5] = regs_reg[6][VCODE_MSB:0];
	assign reg_code[6] = regs_reg[7][VCODE_MSB:0];
	assign reg_code[7] = one_code;
	assign reg_code[8] = two_code;

	// Startup delay fields straight from the register flops
	assign startup_delay_field[0] = regs_reg[1][DELAY_MSB:DELAY_LSB];
	assign startup_delay_field[1] = regs_reg[2][DELAY_MSB:DELAY_LSB];
	assign startup_delay_field[2] = regs_reg[3][DELAY_MSB:DELAY_LSB];
	assign startup_delay_field[3] = regs_reg[4][DELAY_MSB:DELAY_LSB];
	assign startup_delay_field[4] = regs_reg[5][DELAY_MSB:DELAY_LSB];
	assign startup_delay_field[5] = regs_reg[6][DELAY_MSB:DELAY_LSB];
	assign startup_delay_field[6] = regs_reg[7][DELAY_MSB:DELAY_LSB];
	assign startup_delay_field[7] = regs_reg[8][DELAY_MSB:DELAY_LSB];
	assign startup_delay_field[8] = regs_reg[10][DELAY_MSB:DELAY_LSB];

	// Output drives
	assign reg_rd_data          = rd_reg;
	assign stepdown_one_on      = one_on_reg;
	assign stepdown_two_on      = two_on_reg;
	// Members of the next power-up; software keeps no-startup ones clear
	assign stepdown_one_include = gen_now[BIT_ONE_ENABLE];
	assign stepdown_two_include = gen_now[BIT_TWO_ENABLE];
	assign ldo_sleep            = sleep_reg;
	assign sequence_step_cycles = step_reg;
	assign peak_current_limit_ma[0] = climit_one_reg;
	assign peak_current_limit_ma[1] = climit_two_reg;

	// Register file write
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < REG_COUNT; i++)
				regs_reg[i] <= REG_RESET_VALUE;
		end
		else if (wr_hit)
			regs_reg[reg_addr[3:0]] <= wr_value;
	end

	// Read data register, answers one cycle after the address
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rd_reg <= 8'h00;
		else
			rd_reg <= rd_next;
	end

	// Three-stage pin synchroniser, level accepted when stages two and three agree
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pin_s1_reg    <= 1'b0;
			pin_s2_reg    <= 1'b0;
			pin_s3_reg    <= 1'b0;
			pin_level_reg <= 1'b0;
		end
		else
		begin
			pin_s1_reg <= external_voltage_scale_pin;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			if (pin_s2_reg == pin_s3_reg)
				pin_level_reg <= pin_s3_reg;
		end
	end

	// Converter switches, sleep, step and current limit
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			one_on_reg     <= 1'b0;
			two_on_reg     <= 1'b0;
			sleep_reg      <= 1'b0;
			step_reg       <= STEP_32_CYC;
			climit_one_reg <= CLIMIT_MA[0];
			climit_two_reg <= CLIMIT_MA[0];
		end
		else
		begin
			one_on_reg     <= one_on_next;
			two_on_reg     <= two_on_next;
			sleep_reg      <= gen_now[BIT_LDO_SLEEP];
			step_reg       <= step_next;
			climit_one_reg <= CLIMIT_MA[regs_reg[9][CLIMIT_MSB:CLIMIT_LSB]];
			climit_two_reg <= CLIMIT_MA[regs_reg[11][CLIMIT_MSB:CLIMIT_LSB]];
		end
	end

	// Voltage tables: LDOs, low-input regulators, converters
	for (genvar g = 0; g < REG_NUM; g++)
	begin : g_vmap
		// Cast keeps the table choice of enum type for the parameter
		localparam pmurc_tab_e TAB = pmurc_tab_e'((g < 5) ? PMURC_TAB_LDO
			: ((g < 7) ? PMURC_TAB_LOWIN : PMURC_TAB_STEPDOWN));
		pmurc_vmap #(
			.TABLE(TAB)
		) u_vmap (
			.clk       (clk),
			.sys_rst   (sys_rst),
			.volt_code (reg_code[g]),
			.volt_level(regulator_voltage[g])
		);
	end

	// Assertions share one clock and the reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// General register stores masked data
	a_general_write_mask:
	assert property (gen_wr |=> regs_reg[0] == ($past(reg_wr_data) & GENERAL_WRITE_MASK))
		else $error("general register write wrong");

	// Standby keeps converters off from the next edge on
	a_standby_converters_off:
	assert property (!pmu_idle |=> !stepdown_one_on && !stepdown_two_on)
		else $error("converter on in standby");

	// Idle enable write lands on the switch at the same edge
	a_idle_enable_immediate:
	assert property ((pmu_idle && gen_wr) |=>
		stepdown_one_on == $past(reg_wr_data[BIT_ONE_ENABLE]) &&
		stepdown_two_on == $past(reg_wr_data[BIT_TWO_ENABLE]))
		else $error("idle enable not immediate");

	// Sleep output follows the bit after one cycle
	a_ldo_sleep_follow:
	assert property (!$past(sys_rst) |-> ldo_sleep == $past(gen_now[BIT_LDO_SLEEP]))
		else $error("sleep output mismatch");

	// Converter one uses its own code when the select bit is set
	a_one_source_reg:
	assert property ((gen_now[BIT_ONE_SOURCE] && !$past(sys_rst)) |=>
		regulator_voltage[7] == STEPDOWN_TAB[$past(regs_reg[8][VCODE_MSB:0])])
		else $error("converter one source wrong");

	// Converter two picks first or second code
	a_two_source_pick:
	assert property (!$past(sys_rst) |-> regulator_voltage[8] == ($past(gen_now[BIT_TWO_SOURCE])
		? STEPDOWN_TAB[$past(regs_reg[10][VCODE_MSB:0])]
		: STEPDOWN_TAB[$past(regs_reg[11][VCODE_MSB:0])]))
		else $error("converter two source wrong");

	// Longest step is 256 us of clock
	a_step_longest:
	assert property ((gen_now[BIT_STEP_RANGE] && gen_now[BIT_STEP_FINE]) |=>
		sequence_step_cycles == STEP_256_CYC)
		else $error("step count wrong");

	// First LDO voltage tracks its table one cycle late
	a_ldo_table_map:
	assert property (!$past(sys_rst) |-> regulator_voltage[0] == LDO_TAB[$past(reg_code[0])])
		else $error("ldo table mismatch");

	// Low-input regulator voltage tracks its table
	a_lowin_table_map:
	assert property (!$past(sys_rst) |-> regulator_voltage[5] == LOWIN_TAB[$past(reg_code[5])])
		else $error("low-input table mismatch");

	// Peak current follows the field
	a_climit_follow:
	assert property (!$past(sys_rst) |->
		peak_current_limit_ma[1] == CLIMIT_MA[$past(regs_reg[11][CLIMIT_MSB:CLIMIT_LSB])])
		else $error("current limit mismatch");

	// Unmapped reads and the converter one current register answer bit five zero
	a_unused_read_zero:
	assert property ((!addr_mapped || reg_addr == ADDR_STEPDOWN_ONE_B) |=>
		reg_rd_data[5] == 1'b0)
		else $error("unused bit reads nonzero");
endmodule

// *** dv/pmurc_host.sv ***
// Host processor model that writes and reads the register bank
`timescale 1ns/1ps
module pmurc_host
	import pmurc_pkg::*;
(
	// Clock
	input  wire logic                  clk,
	// Register port towards the bank
	output logic                       reg_wr_en,
	output logic      [REG_ADDR_W-1:0] reg_addr,
	output logic      [REG_DATA_W-1:0] reg_wr_data,
	input  wire logic [REG_DATA_W-1:0] reg_rd_data
);
	// Quiet port at time zero
	initial
	begin
		reg_wr_en   = 1'b0;
		reg_addr    = 8'h00;
		reg_wr_data = 8'h00;
	end
	// One write cycle; data turns over once the strobe drops
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr_en   <= 1'b1;
		reg_addr    <= a;
		reg_wr_data <= d;
		@(posedge clk);
		reg_wr_en   <= 1'b0;
		reg_wr_data <= ~d;
	endtask
	// Present an address, take the data one cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
		#1 d = reg_rd_data;
	endtask
	// Software drops a converter enable whose delay slot means no startup
	function automatic logic [7:0] gen_value(input logic [7:0] g, input logic [2:0] d1,
		input logic [2:0] d2);
		return {g[7:5], g[4] & (d2 != 3'h7), g[3:1], g[0] & (d1 != 3'h7)};
	endfunction
endmodule

// *** dv/pmu_regulator_control_regs_tb.sv ***
// Self-checking bench of the regulator control register bank
`timescale 1ns/1ps
module pmu_regulator_control_regs_tb;
	import pmurc_pkg::*;
	// Bench signals
	logic                    clk, sys_rst, reg_wr_en, pmu_idle, scale_pin;
	logic [7:0]              reg_addr, reg_wr_data, reg_rd_data, rd_val, d;
	logic                    one_on, two_on, one_inc, two_inc, ldo_sleep;
	logic [11:0]             step_cyc;
	logic [REG_NUM-1:0][2:0] delay_f;
	logic [REG_NUM-1:0][6:0] volt;
	logic [1:0][10:0]        peak_ma;
	int                      error_cnt, n_tests, seed;
	// Table corners: code and level in 50 mV units
	int lc[3] = '{0, 15, 31};
	int lv[3] = '{24, 40, 66};
	int wc[3] = '{1, 9, 30};
	int wv[3] = '{17, 25, 62};
	int sc[3] = '{0, 16, 31};
	int sv[3] = '{16, 35, 60};
	int pk[4] = '{460, 780, 1050, 1370};
	// Device under test
	pmurc_regs u_dut (
		.clk                        (clk),
		.sys_rst                    (sys_rst),
		.reg_wr_en                  (reg_wr_en),
		.reg_addr                   (reg_addr),
		.reg_wr_data                (reg_wr_data),
		.reg_rd_data                (reg_rd_data),
		.pmu_idle                   (pmu_idle),
		.external_voltage_scale_pin (scale_pin),
		.stepdown_one_on            (one_on),
		.stepdown_two_on            (two_on),
		.stepdown_one_include       (one_inc),
		.stepdown_two_include       (two_inc),
		.ldo_sleep                  (ldo_sleep),
		.sequence_step_cycles       (step_cyc),
		.startup_delay_field        (delay_f),
		.regulator_voltage          (volt),
		.peak_current_limit_ma      (peak_ma)
	);
	// Host on the register port
	pmurc_host u_host (
		.clk         (clk),
		.reg_wr_en   (reg_wr_en),
		.reg_addr    (reg_addr),
		.reg_wr_data (reg_wr_data),
		.reg_rd_data (reg_rd_data)
	);
	// Clock, 100 ns period
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Compare and count
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Let outputs land a number of edges later
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Readable bits per offset; unmapped reads zero
	function automatic logic [7:0] mask_of(input int a);
		return (a == 0 || a == 9 || a == 11) ? 8'hDF : (a < 12 ? 8'hFF : 8'h00);
	endfunction
	// Delay output index of an offset
	function automatic int idx_of(input int a);
		return (a <= 7) ? a - 1 : ((a == 8) ? 7 : 8);
	endfunction
	// Step length in cycles from the two step bits
	function automatic logic [11:0] step_of(input logic [1:0] s);
		return (s == 2'h0) ? 12'd320 : (s == 2'h1) ? 12'd640 : (s == 2'h2) ? 12'd1280 : 12'd2560;
	endfunction
	// Watchdog
	initial
	begin
		repeat (6000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end
	// Main sequence
	initial
	begin
		error_cnt = 0;
		n_tests   = 0;
		seed      = 32'hc48a;
		sys_rst   = 1'b1;
		pmu_idle  = 1'b0;
		scale_pin = 1'b0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		// Reset state
		settle(2);
		check("step", step_cyc, 12'd320);
		check("peak", peak_ma[1], 12'd460);
		check("ldo volt", volt[0], 12'd24);
		check("conv volt", volt[7], 12'd16);
		for (int a = 0; a < 12; a++)
		begin
			u_host.rd(a[7:0], rd_val);
			check("reset read", rd_val, 12'h000);
		end
		$display("test reset done");
		// Enables in standby, then in idle
		u_host.wr(8'h00, 8'hFF);
		u_host.rd(8'h00, rd_val);
		check("general", rd_val, 12'h0DF);
		check("inc one", one_inc, 1'b1);
		check("inc two", two_inc, 1'b1);
		check("on one", one_on, 1'b0);
		check("sleep", ldo_sleep, 1'b1);
		check("step", step_cyc, 12'd2560);
		@(posedge clk);
		pmu_idle <= 1'b1;
		settle(2);
		check("on one", one_on, 1'b1);
		check("on two", two_on, 1'b1);
		u_host.wr(8'h00, 8'h00);
		settle(1);
		check("off one", one_on, 1'b0);
		check("off two", two_on, 1'b0);
		settle(1);
		check("sleep", ldo_sleep, 1'b0);
		for (int k = 0; k < 4; k++)
		begin
			u_host.wr(8'h00, {k[1:0], 6'h00});
			settle(2);
			check("step", step_cyc, step_of(k[1:0]));
		end
		$display("test general done");
		// Voltage tables at their corners
		u_host.wr(8'h00, 8'h04);
		for (int i = 0; i < 3; i++)
		begin
			u_host.wr(8'h01, lc[i][7:0]);
			u_host.wr(8'h06, wc[i][7:0]);
			u_host.wr(8'h08, sc[i][7:0]);
			u_host.wr(8'h0B, sc[i][7:0]);
			settle(3);
			check("ldo volt", volt[0], lv[i][11:0]);
			check("lowin volt", volt[5], wv[i][11:0]);
			check("conv one", volt[7], sv[i][11:0]);
			check("conv two", volt[8], sv[i][11:0]);
		end
		$display("test tables done");
		// Source selection: pin, first and second codes
		u_host.wr(8'h08, 8'h03);
		u_host.wr(8'h09, 8'h1F);
		u_host.wr(8'h0A, 8'h10);
		u_host.wr(8'h0B, 8'h00);
		u_host.wr(8'h00, 8'h00);
		settle(8);
		check("pin low", volt[7], 12'd19);
		check("second", volt[8], 12'd16);
		@(posedge clk);
		scale_pin <= 1'b1;
		settle(8);
		check("pin high", volt[7], 12'd60);
		u_host.wr(8'h00, 8'h0C);
		settle(8);
		check("first one", volt[7], 12'd19);
		check("first two", volt[8], 12'd35);
		for (int k = 0; k < 4; k++)
		begin
			u_host.wr(8'h09, {k[1:0], 6'h00});
			u_host.wr(8'h0B, {2'(3 - k), 6'h00});
			settle(2);
			check("peak one", peak_ma[0], pk[k][11:0]);
			check("peak two", peak_ma[1], pk[3 - k][11:0]);
		end
		$display("test select done");
		// Random fill and readback of every offset
		for (int a = 0; a < 16; a++)
		begin
			d = 8'($random(seed));
			u_host.wr(a[7:0], d);
			u_host.rd(a[7:0], rd_val);
			check("readback", rd_val, d & mask_of(a));
			if (a >= 1 && a <= 10 && a != 9)
				check("delay", delay_f[idx_of(a)], d[7:5]);
		end
		u_host.wr(8'hFF, 8'hFF);
		u_host.rd(8'hFF, rd_val);
		check("unmapped", rd_val, 12'h000);
		// No-startup slot with its enable dropped by software
		u_host.wr(8'h08, 8'hE0);
		u_host.wr(8'h00, u_host.gen_value(8'h11, 3'h7, 3'h0));
		settle(2);
		check("inc one", one_inc, 1'b0);
		check("inc two", two_inc, 1'b1);
		$display("test random done");
		tally_and_finish();
	end
endmodule
